// ---- core/sfc_pkg.sv ----
// sfc_pkg: register map, field layouts and link carriers of the spi port.
// assumes one 32-bit byte address per register and 16-bit register data.
package sfc_pkg;
   localparam logic [31:0] ADDR_STATUS = 32'hFFFF0A00;
   localparam logic [31:0] ADDR_RXDATA = 32'hFFFF0A04;
   localparam logic [31:0] ADDR_TXDATA = 32'hFFFF0A08;
   localparam logic [31:0] ADDR_DIV = 32'hFFFF0A0C;
   localparam logic [31:0] ADDR_CTRL = 32'hFFFF0A10;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [5:0] DIV_RST = 6'h00;
   localparam logic [5:0] DIV_MAX = 6'h3F;
   localparam logic [7:0] RXDATA_RST = 8'h00;
   localparam logic [7:0] FILL_ZERO = 8'h00;
   localparam logic [15:0] RDATA_RST = 16'h0000;

   // port_control layout, bit 15 first
   typedef struct packed {
      logic [1:0] threshold;
      logic tx_flush;
      logic rx_flush;
      logic continuous;
      logic [1:0] spare_hi;
      logic overwrite;
      logic zero_fill;
      logic trigger_tx;
      logic [5:0] spare_lo;
   } sfc_ctrl_t;

   // port_status layout, bit 15 first
   typedef struct packed {
      logic [3:0] reserved;
      logic rx_excess;
      logic [2:0] rx_level;
      logic rx_overflow;
      logic rx_irq;
      logic tx_irq;
      logic tx_underflow;
      logic [2:0] tx_level;
      logic summary;
   } sfc_stat_t;

   // a byte handed across the clock boundary with its event toggle
   typedef struct packed {
      logic [7:0] data;
      logic tgl;
   } sfc_tok_t;
endpackage : sfc_pkg

// ---- core/sfc_link.sv ----
// sfc_link: serial shifter of the spi port, slave side, on the link clock.
// assumes sclk idles low, data launched on rising and sampled on falling edges,
// and sclk stands still while the select pin is high.
`timescale 1ns/100ps
module sfc_link (
   input wire logic i_sclk,
   input wire logic i_rst_n,
   input wire logic i_ss_n,
   input wire logic i_mosi,
   input wire sfc_pkg::sfc_tok_t i_tx,
   input wire logic i_zero_fill,
   output logic o_miso,
   output logic o_miso_oe,
   output sfc_pkg::sfc_tok_t o_rx,
   output logic o_ack
);
   logic tgl_s1, tgl_s2, zf_s1, zf_s2;
   logic [7:0] last;
   logic [2:0] tx_bit, rx_bit;
   logic [7:0] tx_sh, rx_sh;

   wire fresh = tgl_s2 != o_ack;
   wire byte_start = tx_bit == 3'h0;
   // with no fresh byte the last value goes out again, or zero when asked
   wire [7:0] fill = zf_s2 ? sfc_pkg::FILL_ZERO : last;
   wire [7:0] next_byte = fresh ? i_tx.data : fill;
   wire [7:0] rx_full = {rx_sh[6:0], i_mosi};

   always_ff @(posedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         zf_s1 <= 1'b0;
         zf_s2 <= 1'b0;
         o_ack <= 1'b0;
         last <= sfc_pkg::FILL_ZERO;
      end else begin
         tgl_s1 <= i_tx.tgl;
         tgl_s2 <= tgl_s1;
         zf_s1 <= i_zero_fill;
         zf_s2 <= zf_s1;
         if (byte_start) begin
            last <= next_byte;
            o_ack <= o_ack ^ fresh;
         end
      end
   end

   // frame state is cleared by the select pin itself, since sclk stops
   always_ff @(posedge i_sclk or negedge i_rst_n or posedge i_ss_n) begin
      if (!i_rst_n) begin
         tx_bit <= 3'h0;
         tx_sh <= sfc_pkg::FILL_ZERO;
         o_miso <= 1'b0;
         o_miso_oe <= 1'b0;
      end else if (i_ss_n) begin
         tx_bit <= 3'h0;
         tx_sh <= sfc_pkg::FILL_ZERO;
         o_miso <= 1'b0;
         o_miso_oe <= 1'b0;
      end else begin
         tx_bit <= tx_bit + 3'h1;
         o_miso_oe <= 1'b1;
         tx_sh <= byte_start ? {next_byte[6:0], 1'b0} : {tx_sh[6:0], 1'b0};
         o_miso <= byte_start ? next_byte[7] : tx_sh[7];
      end
   end

   always_ff @(negedge i_sclk or negedge i_rst_n or posedge i_ss_n) begin
      if (!i_rst_n) begin
         rx_bit <= 3'h0;
         rx_sh <= sfc_pkg::FILL_ZERO;
      end else if (i_ss_n) begin
         rx_bit <= 3'h0;
         rx_sh <= sfc_pkg::FILL_ZERO;
      end else begin
         rx_bit <= rx_bit + 3'h1;
         rx_sh <= rx_full;
      end
   end

   always_ff @(negedge i_sclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx <= '0;
      end else if (!i_ss_n && rx_bit == 3'h7) begin
         o_rx.data <= rx_full;
         o_rx.tgl <= ~o_rx.tgl;
      end
   end
endmodule : sfc_link

// ---- core/sfc_spi_port.sv ----
// sfc_spi_port: register file, fifos and flags of the spi port.
// assumes a memory-mapped register port on I_CLK_SYS and an spi master on the pins.
// Notes on behaviour
// - in transmit-trigger mode, threshold bytes sent sets tx interrupt flag; status read clears
// - transfer start with empty tx fifo sets underflow; interrupts unless tx flush or rx flush
// - status bits 3:1 give tx fifo level, 0 to 4 bytes
// - status bit 0 sets on any port interrupt, cleared by status read
// - receive data register, 8 bits, read only, resets to 0x00
// - transmit data register, 8 bits, write only, writes queue bytes
// - bit rate divider, 6 bits read/write, resets to zero, max 0x3F
// - control 15:14 picks threshold of one to four bytes for both interrupts
// - control bit 13 keeps tx fifo flushed while set, never self clears
// - during tx flush the link sends last byte or zero per zero fill
// - tx fifo writes are dropped while tx flush is set
// - control bit 12 keeps rx fifo flushed while set, never self clears
// - during rx flush incoming bytes are ignored and no interrupts raised
// - rx flush with receive-trigger mode: a receive read starts a transfer
// - control bit 11 enables back-to-back continuous transfer
// - continuous off: one byte per start; on: bytes flow while fifo holds data
// - trigger mode set: tx write starts, tx interrupts; clear: rx read, rx interrupts
// - byte arriving with rx fifo full sets overflow; interrupts unless rx flush
`timescale 1ns/100ps
module sfc_spi_port #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   input wire logic [31:0] I_ADDR,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [15:0] I_WDATA,
   output logic [15:0] O_RDATA,
   output logic O_IRQ,
   input wire logic I_SCLK,
   input wire logic I_SS_B,
   input wire logic I_MOSI,
   output logic O_MISO,
   output logic O_MISO_OE
);
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam logic [2:0] DEPTH3 = 3'(FIFO_DEPTH);

   // level codes are three bits and pointers wrap by width
   if (FIFO_DEPTH != 2 && FIFO_DEPTH != 4) begin : g_depth_check
      $error("FIFO_DEPTH must be 2 or 4");
   end

   function automatic logic meets_thr(input logic [2:0] lvl, input logic [1:0] thr);
      meets_thr = lvl >= ({1'b0, thr} + 3'h1);
   endfunction : meets_thr

   logic rst_m, rst_n;
   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   sfc_pkg::sfc_ctrl_t ctrl;
   logic [5:0] div;
   logic [7:0] tx_mem [FIFO_DEPTH];
   logic [7:0] rx_mem [FIFO_DEPTH];
   logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
   logic [2:0] tx_lvl, rx_lvl, credit, sent_cnt;
   sfc_pkg::sfc_tok_t tx_tok, rx_tok;
   logic ack, ack_s1, ack_s2, ack_s3, rx_s1, rx_s2, rx_s3;
   logic f_tx_irq, f_rx_irq, f_ufl, f_ovf, f_sum;

   // register decode
   wire rd_stat = I_RD && I_ADDR == sfc_pkg::ADDR_STATUS;
   wire rd_rx = I_RD && I_ADDR == sfc_pkg::ADDR_RXDATA;
   wire wr_tx = I_WR && I_ADDR == sfc_pkg::ADDR_TXDATA;
   wire wr_div = I_WR && I_ADDR == sfc_pkg::ADDR_DIV;
   wire wr_ctrl = I_WR && I_ADDR == sfc_pkg::ADDR_CTRL;

   // transmit side
   wire tx_full = tx_lvl == DEPTH3;
   wire tx_empty = tx_lvl == 3'h0;
   wire push = wr_tx && !ctrl.tx_flush && !tx_full;
   wire trig = ctrl.trigger_tx ? (wr_tx && !ctrl.tx_flush) : rd_rx;
   wire tx_pend = tx_tok.tgl != ack_s2;
   wire feed = !tx_pend && !tx_empty && !ctrl.tx_flush
      && (ctrl.continuous || credit != 3'h0);
   // a trigger-mode write brings its own byte, so only a bare start underflows
   wire ufl_evt = trig && tx_empty && !tx_pend && !push;
   wire sent_evt = ack_s2 ^ ack_s3;
   wire [2:0] sent_next = sent_cnt + 3'h1;
   wire tx_irq_evt = sent_evt && ctrl.trigger_tx && meets_thr(sent_next, ctrl.threshold);
   // an underflowing start goes out as fill and leaves no credit behind
   wire [2:0] credit_up = (trig && !ufl_evt && credit != DEPTH3) ? credit + 3'h1 : credit;

   // receive side
   wire rx_full = rx_lvl == DEPTH3;
   wire rx_evt = (rx_s2 ^ rx_s3) && !ctrl.rx_flush;
   wire pop_rx = rd_rx && rx_lvl != 3'h0 && !ctrl.rx_flush;
   wire ovf_evt = rx_evt && rx_full;
   wire rx_store = rx_evt && (!rx_full || ctrl.overwrite);
   wire [2:0] rx_new_lvl = rx_full ? rx_lvl : rx_lvl + 3'h1;
   wire rx_irq_evt = rx_evt && !ctrl.trigger_tx && meets_thr(rx_new_lvl, ctrl.threshold);
   // overwrite replaces the newest entry, so the byte at the head stays put
   wire [AW-1:0] rx_slot = (rx_full && ctrl.overwrite) ? rx_wp - 1'b1 : rx_wp;
   wire sum_set = (tx_irq_evt || rx_irq_evt || (ufl_evt && !ctrl.tx_flush) || ovf_evt)
      && !ctrl.rx_flush;

   sfc_pkg::sfc_stat_t stat_w;
   assign stat_w = '{reserved: 4'h0, rx_excess: rx_lvl > ({1'b0, ctrl.threshold} + 3'h1),
      rx_level: rx_lvl, rx_overflow: f_ovf, rx_irq: f_rx_irq, tx_irq: f_tx_irq,
      tx_underflow: f_ufl, tx_level: tx_lvl, summary: f_sum};
   wire [7:0] rx_head = rx_lvl == 3'h0 ? sfc_pkg::RXDATA_RST : rx_mem[rx_rp];
   // read data stands one cycle; unmapped and write-only addresses read as zero
   wire [15:0] next_rdata = rd_stat ? stat_w
      : rd_rx ? {8'h00, rx_head}
      : (I_RD && I_ADDR == sfc_pkg::ADDR_DIV) ? {10'h000, div}
      : (I_RD && I_ADDR == sfc_pkg::ADDR_CTRL) ? ctrl
      : sfc_pkg::RDATA_RST;

   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= sfc_pkg::CTRL_RST;
         div <= sfc_pkg::DIV_RST;
         O_RDATA <= sfc_pkg::RDATA_RST;
      end else begin
         O_RDATA <= next_rdata;
         if (wr_ctrl) ctrl <= I_WDATA;
         if (wr_div) div <= I_WDATA[5:0];
      end
   end

   // sticky flags: a set in the clearing cycle survives the status read
   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         f_tx_irq <= 1'b0;
         f_rx_irq <= 1'b0;
         f_ufl <= 1'b0;
         f_ovf <= 1'b0;
         f_sum <= 1'b0;
      end else begin
         f_tx_irq <= tx_irq_evt || (f_tx_irq && !rd_stat);
         f_rx_irq <= rx_irq_evt || (f_rx_irq && !rd_stat);
         f_ufl <= ufl_evt || (f_ufl && !rd_stat);
         f_ovf <= ovf_evt || (f_ovf && !rd_stat);
         f_sum <= sum_set || (f_sum && !rd_stat);
      end
   end
   assign O_IRQ = f_sum;

   always_ff @(posedge I_CLK_SYS) begin
      if (push) tx_mem[tx_wp] <= I_WDATA[7:0];
      if (rx_store) rx_mem[rx_slot] <= rx_tok.data;
   end

   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_lvl <= 3'h0;
         credit <= 3'h0;
         tx_tok <= '0;
      end else if (ctrl.tx_flush) begin
         tx_wp <= '0;
         tx_rp <= '0;
         tx_lvl <= 3'h0;
         credit <= 3'h0;
      end else begin
         if (push) tx_wp <= tx_wp + 1'b1;
         if (feed) tx_rp <= tx_rp + 1'b1;
         tx_lvl <= tx_lvl + {2'h0, push} - {2'h0, feed};
         credit <= (feed && credit_up != 3'h0) ? credit_up - 3'h1 : credit_up;
         if (feed) begin
            tx_tok.data <= tx_mem[tx_rp];
            tx_tok.tgl <= ~tx_tok.tgl;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         sent_cnt <= 3'h0;
      end else if (sent_evt) begin
         sent_cnt <= tx_irq_evt ? 3'h0 : sent_next;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_lvl <= 3'h0;
      end else if (ctrl.rx_flush) begin
         rx_wp <= '0;
         rx_rp <= '0;
         rx_lvl <= 3'h0;
      end else begin
         if (rx_store && !rx_full) rx_wp <= rx_wp + 1'b1;
         if (pop_rx) rx_rp <= rx_rp + 1'b1;
         rx_lvl <= rx_lvl + {2'h0, rx_evt && !rx_full} - {2'h0, pop_rx};
      end
   end

   // toggles from the link clock cross through two flops before any use
   always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
         rx_s3 <= 1'b0;
      end else begin
         ack_s1 <= ack;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
         rx_s1 <= rx_tok.tgl;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
      end
   end

   // rx data is only read after its toggle is seen, so it has long settled
   sfc_link u_link (
      .i_sclk(I_SCLK),
      .i_rst_n(rst_n),
      .i_ss_n(I_SS_B),
      .i_mosi(I_MOSI),
      .i_tx(tx_tok),
      .i_zero_fill(ctrl.zero_fill),
      .o_miso(O_MISO),
      .o_miso_oe(O_MISO_OE),
      .o_rx(rx_tok),
      .o_ack(ack)
   );

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!rst_n);

   tx_irq_mode_a: assert property ($rose(f_tx_irq) |->
      $past(ctrl.trigger_tx) && $past(sent_evt))
      else $error("tx interrupt flag set outside transmit trigger mode");
   underflow_set_a: assert property (trig && tx_empty && !tx_pend && !push |=> f_ufl)
      else $error("underflow flag missed on empty start");
   tx_level_rd_a: assert property (rd_stat |=> O_RDATA[3:1] == $past(tx_lvl))
      else $error("status level field wrong");
   summary_clear_a: assert property (rd_stat && !sum_set |=> !f_sum && !O_IRQ)
      else $error("summary bit not cleared by status read");
   rx_empty_rd_a: assert property (rd_rx && rx_lvl == 3'h0 |=> O_RDATA == 16'h0000)
      else $error("empty receive read not zero");
   divider_wr_a: assert property (wr_div ##1 !wr_div |-> div == $past(I_WDATA[5:0]))
      else $error("divider write lost");
   tx_flush_hold_a: assert property (ctrl.tx_flush |=> tx_lvl == 3'h0 && !feed)
      else $error("tx fifo not held empty");
   tx_wr_drop_a: assert property (ctrl.tx_flush && wr_tx |=> $stable(tx_wp))
      else $error("tx write taken during flush");
   rx_flush_quiet_a: assert property (ctrl.rx_flush && $past(ctrl.rx_flush) |->
      !$rose(f_sum))
      else $error("interrupt raised during rx flush");
   single_feed_a: assert property (!ctrl.continuous && credit == 3'h0 |-> !feed)
      else $error("byte fed without a start");
   overflow_set_a: assert property (ovf_evt |=> f_ovf && f_sum)
      else $error("overflow not flagged");
   irq_rise_a: assert property ($rose(O_IRQ) |-> $past(sum_set))
      else $error("interrupt request without cause");
   // sticky flags drop on a status read unless a fresh event lands in that cycle
   tx_irq_clear_a: assert property (rd_stat && !tx_irq_evt |=> !f_tx_irq)
      else $error("tx interrupt flag not cleared by status read");
   ufl_clear_a: assert property (rd_stat && !ufl_evt |=> !f_ufl)
      else $error("underflow flag not cleared by status read");
   ufl_flush_quiet_a: assert property (ufl_evt && ctrl.tx_flush && !f_sum
      && !tx_irq_evt && !rx_irq_evt && !ovf_evt |=> !f_sum)
      else $error("underflow raised an interrupt during tx flush");
   level_range_a: assert property (tx_lvl <= DEPTH3 && rx_lvl <= DEPTH3)
      else $error("fifo level beyond depth");
   rx_pop_level_a: assert property (pop_rx && !rx_evt |=> rx_lvl == $past(rx_lvl) - 3'h1)
      else $error("receive read did not pop one byte");
   rdata_idle_a: assert property (!I_RD |=> O_RDATA == sfc_pkg::RDATA_RST)
      else $error("read data stands longer than one cycle");
   tx_push_level_a: assert property (push && !feed |=> tx_lvl == $past(tx_lvl) + 3'h1)
      else $error("accepted tx byte not counted");
   rx_irq_thr_a: assert property ($rose(f_rx_irq) |-> !$past(ctrl.trigger_tx)
      && $past(rx_lvl) >= {1'b0, $past(ctrl.threshold)})
      else $error("rx interrupt below threshold");
   rx_flush_hold_a: assert property (ctrl.rx_flush |=> rx_lvl == 3'h0)
      else $error("rx fifo not held empty");
   rx_flush_flags_a: assert property (ctrl.rx_flush && $past(ctrl.rx_flush)
      |-> !$rose(f_rx_irq) && !$rose(f_ovf))
      else $error("receive flag raised during rx flush");
   credit_use_a: assert property (!ctrl.continuous && feed && !trig |=>
      credit == $past(credit) - 3'h1)
      else $error("single transfer fed without spending its start");
   ovf_clear_a: assert property (rd_stat && !ovf_evt |=> !f_ovf)
      else $error("overflow flag not cleared by status read");

   feed_cov: cover property (feed ##[1:400] sent_evt);
   rx_irq_cov: cover property (rx_irq_evt);
   ovf_cov: cover property (ovf_evt && ctrl.overwrite);
   ufl_cov: cover property (ufl_evt && !ctrl.trigger_tx);
   cont_feed_cov: cover property (feed && ctrl.continuous && credit == 3'h0);
endmodule : sfc_spi_port

// ---- sim/sfc_master_model.sv ----
// sfc_master_model: spi master standing in front of the port's pins.
// assumes sclk idles low, 125 ns serial period, one byte per frame.
`timescale 1ns/100ps
module sfc_master_model (
   output logic o_sclk,
   output logic o_ss_b,
   output logic o_mosi,
   input wire logic i_miso
);
   initial begin
      o_sclk = 1'b0;
      o_ss_b = 1'b1;
      o_mosi = 1'b1;
   end

   // sclk only runs inside a frame, so the port's sclk-side sync sees no edges between frames
   task automatic frame(input logic [7:0] d, output logic [7:0] q);
      o_ss_b = 1'b0;
      #100;
      for (int i = 7; i >= 0; i--) begin
         o_sclk = 1'b1;
         o_mosi = d[i];
         #62.5;
         q[i] = i_miso;
         o_sclk = 1'b0;
         #62.5;
      end
      o_ss_b = 1'b1;
      // released line flips so no stale bit can be mistaken for data
      o_mosi = ~o_mosi;
      #250;
   endtask : frame
endmodule : sfc_master_model

// ---- sim/test_sfc_spi_port.sv ----
// test_sfc_spi_port: register-level tests of the spi port with a master model.
// assumes read data one cycle after the strobe and 50 MHz system clock.
`timescale 1ns/100ps
module test_sfc_spi_port;
   localparam logic [31:0] ST = sfc_pkg::ADDR_STATUS;
   localparam logic [31:0] RX = sfc_pkg::ADDR_RXDATA;
   localparam logic [31:0] TX = sfc_pkg::ADDR_TXDATA;
   localparam logic [31:0] DV = sfc_pkg::ADDR_DIV;
   localparam logic [31:0] CT = sfc_pkg::ADDR_CTRL;
   logic clk, rst_b, wr, rd, irq, sclk, ss_b, mosi, miso_q, miso_oe;
   logic [31:0] addr;
   logic [15:0] wdata, rdata, q;
   logic [7:0] b;
   wire miso;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;

   // a released line shows the inverse so a stale bit cannot pass for data
   assign miso = miso_oe ? miso_q : ~miso_q;

   sfc_spi_port #(.FIFO_DEPTH(4)) u_dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_ADDR(addr),
      .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .O_RDATA(rdata), .O_IRQ(irq), .I_SCLK(sclk),
      .I_SS_B(ss_b), .I_MOSI(mosi), .O_MISO(miso_q), .O_MISO_OE(miso_oe));
   sfc_master_model u_mst (.o_sclk(sclk), .o_ss_b(ss_b), .o_mosi(mosi), .i_miso(miso));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic check(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check

   task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // reads pop and clear, so every read is one strobe and its data is taken once
   task automatic rd_chk(input logic [31:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      q = rdata;
      check(q & m, e);
   endtask : rd_chk

   task automatic xfer(input logic [7:0] d);
      u_mst.frame(d, b);
      repeat (10) @(posedge clk);
   endtask : xfer

   initial begin
      rst_b = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 32'h00000000;
      wdata = 16'h0000;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(ST, 16'hFFFF, 16'h0000);
      rd_chk(RX, 16'hFFFF, 16'h0000);
      check({15'h0000, irq}, 16'h0001);
      rd_chk(ST, 16'hFFFF, 16'h0011);
      check({15'h0000, irq}, 16'h0000);
      rd_chk(ST, 16'hFFFF, 16'h0000);
      rd_chk(DV, 16'hFFFF, 16'h0000);
      rd_chk(CT, 16'hFFFF, 16'h0000);
      rd_chk(32'hFFFF0A14, 16'hFFFF, 16'h0000);
      wr_reg(DV, 16'hFFFF);
      rd_chk(DV, 16'hFFFF, 16'h003F);
      rd_chk(TX, 16'hFFFF, 16'h0000);
      // receive-trigger mode: tx writes only queue, so the level counts up
      for (int i = 1; i <= 5; i++) begin
         wr_reg(TX, 16'(16'h0010 + i));
         rd_chk(ST, 16'h000E, 16'((i > 4 ? 4 : i) * 2));
      end
      wr_reg(CT, 16'h2000);
      rd_chk(ST, 16'h000E, 16'h0000);
      wr_reg(TX, 16'h0077);
      rd_chk(ST, 16'h000E, 16'h0000);
      rd_chk(RX, 16'h00FF, 16'h0000);
      rd_chk(ST, 16'h0011, 16'h0010);
      wr_reg(CT, 16'hC000);
      rd_chk(ST, 16'h000E, 16'h0000);
      xfer(8'h11);
      xfer(8'h22);
      xfer(8'h33);
      rd_chk(ST, 16'h0741, 16'h0300);
      xfer(8'h44);
      check({15'h0000, irq}, 16'h0001);
      rd_chk(ST, 16'h0741, 16'h0441);
      xfer(8'h55);
      rd_chk(ST, 16'h0781, 16'h0481);
      rd_chk(RX, 16'hFFFF, 16'h0011);
      rd_chk(ST, 16'h0711, 16'h0311);
      wr_reg(CT, 16'hD000);
      rd_chk(ST, 16'h0700, 16'h0000);
      xfer(8'h99);
      check({15'h0000, irq}, 16'h0000);
      rd_chk(ST, 16'h07C1, 16'h0000);
      rd_chk(RX, 16'hFFFF, 16'h0000);
      rd_chk(ST, 16'h0011, 16'h0010);
      wr_reg(CT, 16'h0040);
      rd_chk(ST, 16'hFFFF, 16'h0000);
      wr_reg(TX, 16'h00A5);
      // the byte reaches the sclk side only after two sclk rising edges, so frame one is fill
      xfer(8'h01);
      check({8'h00, b}, 16'h0000);
      xfer(8'h02);
      check({8'h00, b}, 16'h00A5);
      rd_chk(ST, 16'h0021, 16'h0021);
      wr_reg(CT, 16'h2040);
      xfer(8'h03);
      check({8'h00, b}, 16'h00A5);
      // zero fill reaches the sclk side one frame late, as sclk stops between frames
      wr_reg(CT, 16'h20C0);
      xfer(8'h04);
      xfer(8'h05);
      check({8'h00, b}, 16'h0000);
      // continuous in receive-trigger mode: queued bytes flow with no start
      wr_reg(CT, 16'h0800);
      wr_reg(TX, 16'h003C);
      wr_reg(TX, 16'h005A);
      rd_chk(ST, 16'h000E, 16'h0002);
      xfer(8'h06);
      xfer(8'h07);
      check({8'h00, b}, 16'h003C);
      xfer(8'h08);
      check({8'h00, b}, 16'h005A);
      rd_chk(ST, 16'h000E, 16'h0000);
      end_of_test();
   end
endmodule : test_sfc_spi_port
